// *** cidc_asserts.sv ***
// Port-level timing checker for the decoder, bound to its top
`timescale 1ns/1ns
`default_nettype none
module cidc_asserts (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [15:0] INSTR_I,
    input wire logic [3:0] BIT_INDEX_TEMP_REG_I,
    input wire logic IRQ_I,
    input wire logic INSTR_TAKE_O,
    input wire logic OP_VALID_O,
    input wire cidc_pkg::cidc_op_t OP_O,
    input wire logic [1:0] OP_CYCLES_O,
    input wire logic [3:0] TEST_BIT_SEL_O,
    input wire logic [15:0] OPERAND2_O,
    input wire logic GLOBAL_IRQ_MASK_O,
    input wire logic OVF_MODE_O,
    input wire logic RAM_CONFIG_BIT_O,
    input wire logic SIGN_EXT_MODE_O,
    input wire logic HOLD_MODE_O,
    input wire logic TEST_CONTROL_FLAG_O,
    input wire logic CARRY_O,
    input wire logic EXTERNAL_FLAG_PIN_O,
    input wire logic DEEP_SLEEP_O,
    input wire logic CLEAR_ACC_PRODUCT_REGISTER_O
);
    import cidc_pkg::*;
    logic [15:0] pw;
    logic [3:0] pt;
    logic [7:0] md;
    assign md = {CARRY_O, EXTERNAL_FLAG_PIN_O, TEST_CONTROL_FLAG_O,
        HOLD_MODE_O, SIGN_EXT_MODE_O, RAM_CONFIG_BIT_O, OVF_MODE_O,
        GLOBAL_IRQ_MASK_O};
    // Inputs seen at the take edge, where the op also issues; the checks sample both one edge later
    always_ff @(posedge REF_CLK_I) begin
        pw <= INSTR_I;
        pt <= BIT_INDEX_TEMP_REG_I;
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    property p_bit_sel;
        OP_VALID_O && OP_O == OPC_BIT_IMM |-> TEST_BIT_SEL_O == pw[11:8];
    endproperty
    a_bit_sel: assert property (p_bit_sel)
        else $error("bit select");
    property p_var_sel;
        OP_VALID_O && OP_O == OPC_VAR_BIT_TEST |-> TEST_BIT_SEL_O == pt;
    endproperty
    a_var_sel: assert property (p_var_sel)
        else $error("var select");
    property p_ctl_bit;
        OP_VALID_O && OP_O inside {OPC_SET_CTL, OPC_CLEAR_CTL}
            |-> md[pw[3:1]] == pw[0];
    endproperty
    a_ctl_bit: assert property (p_ctl_bit)
        else $error("ctl bit");
    property p_ctl_hold;
        !OP_VALID_O |-> $stable(md);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold)
        else $error("mode drift");
    // Second words of loop ops may look like flag words; only controls count
    property p_xf;
        OP_VALID_O && OP_O inside {OPC_SET_CTL, OPC_CLEAR_CTL} &&
            pw[15:1] == 15'h5F26 |-> EXTERNAL_FLAG_PIN_O == pw[0];
    endproperty
    a_xf: assert property (p_xf)
        else $error("flag pin");
    // Wake needs the interrupt through both flops, so three samples matter
    property p_deep;
        DEEP_SLEEP_O && !$past(IRQ_I) && !$past(IRQ_I, 2) &&
            !$past(IRQ_I, 3) |-> ##2 !INSTR_TAKE_O;
    endproperty
    a_deep: assert property (p_deep)
        else $error("woke early");
    property p_two_cyc;
        OP_VALID_O && OP_O inside {OPC_LOAD_ST0, OPC_LOAD_ST1, OPC_RPT_DATA,
            OPC_RPT_SHORT} |-> OP_CYCLES_O == CYC_TWO ##1 !INSTR_TAKE_O;
    endproperty
    a_two_cyc: assert property (p_two_cyc)
        else $error("busy");
    property p_one_cyc;
        OP_VALID_O && OP_O inside {OPC_STORE_ST0, OPC_STORE_ST1,
            OPC_STACK_TO_MEM, OPC_MEM_TO_STACK} |-> OP_CYCLES_O == CYC_ONE;
    endproperty
    a_one_cyc: assert property (p_one_cyc)
        else $error("cycles");
    property p_nop;
        OP_VALID_O && OP_O == OPC_NOP |-> $stable(md) && !CLEAR_ACC_PRODUCT_REGISTER_O;
    endproperty
    a_nop: assert property (p_nop)
        else $error("nop effect");
    property p_block;
        OP_VALID_O && OP_O == OPC_BLOCK_LOOP
            |-> OPERAND2_O == pw && OP_CYCLES_O == CYC_TWO;
    endproperty
    a_block: assert property (p_block)
        else $error("block loop");
    property p_zero;
        CLEAR_ACC_PRODUCT_REGISTER_O || (OP_VALID_O && OP_O == OPC_ZERO_LOOP)
            |-> CLEAR_ACC_PRODUCT_REGISTER_O && OP_VALID_O && OP_O == OPC_ZERO_LOOP;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero loop");
endmodule : cidc_asserts
bind cidc_decoder cidc_asserts cidc_asserts_i (.*);
`default_nettype wire

// *** cidc_classify.sv ***
// Combinational opcode classifier: word to operation, word and cycle counts
`timescale 1ns/1ns
`default_nettype none
module cidc_classify (
    input wire logic [15:0] instr_i,
    output cidc_pkg::cidc_op_t op_o,
    output logic two_word_o,
    output logic [1:0] cycles_o
);
    import cidc_pkg::*;

    logic [7:0] hi;
    assign hi = instr_i[BYTE_HI:BYTE_LO];

    always_comb begin
        op_o = OPC_NONE;
        two_word_o = 1'b0;
        cycles_o = CYC_ONE;
        if (instr_i[NIB_HI:NIB_LO] == OP_BIT_IMM) begin
            op_o = OPC_BIT_IMM; // see [RL1]
        end else if (hi == OP_VAR_BIT_TEST) begin
            op_o = OPC_VAR_BIT_TEST; // see [RL2]
        end else if (instr_i[15:4] == OP_CTL_GROUP) begin
            op_o = instr_i[0] ? OPC_SET_CTL : OPC_CLEAR_CTL; // see [RL3]
        end else if (instr_i == OP_IDLE) begin
            op_o = OPC_IDLE; // see [RL6]
        end else if (instr_i == OP_DEEP_SLEEP) begin
            op_o = OPC_DEEP_SLEEP; // see [RL6]
        end else if (hi == OP_LOAD_ST0 || hi == OP_LOAD_ST1) begin
            op_o = (hi == OP_LOAD_ST0) ? OPC_LOAD_ST0 : OPC_LOAD_ST1;
            cycles_o = CYC_TWO; // see [RL7]
        end else if (hi == OP_STORE_ST0) begin
            op_o = OPC_STORE_ST0; // see [RL8]
        end else if (hi == OP_STORE_ST1) begin
            op_o = OPC_STORE_ST1; // see [RL8]
        end else if (instr_i == OP_NOP) begin
            op_o = OPC_NOP; // see [RL9]
        end else if (instr_i == OP_POP_ACC_LOW_HALF) begin
            op_o = OPC_POP_ACC_LOW_HALF; // see [RL10]
        end else if (instr_i == OP_PUSH_ACC_LOW_HALF) begin
            op_o = OPC_PUSH_ACC_LOW_HALF; // see [RL10]
        end else if (hi == OP_STACK_TO_MEM) begin
            op_o = OPC_STACK_TO_MEM; // see [RL11]
        end else if (hi == OP_MEM_TO_STACK) begin
            op_o = OPC_MEM_TO_STACK; // see [RL11]
        end else if (hi == OP_RPT_DATA) begin
            op_o = OPC_RPT_DATA;
            cycles_o = CYC_TWO; // see [RL12]
        end else if (instr_i == OP_RPT_LONG) begin
            op_o = OPC_RPT_LONG;
            two_word_o = 1'b1;
            cycles_o = CYC_TWO; // see [RL12]
        end else if (hi == OP_RPT_SHORT) begin
            op_o = OPC_RPT_SHORT;
            cycles_o = CYC_TWO; // see [RL12]
        end else if (instr_i == OP_BLOCK_LOOP) begin
            op_o = OPC_BLOCK_LOOP;
            two_word_o = 1'b1;
            cycles_o = CYC_TWO; // see [RL13]
        end else if (instr_i == OP_ZERO_LOOP) begin
            op_o = OPC_ZERO_LOOP;
            two_word_o = 1'b1;
            cycles_o = CYC_TWO; // see [RL14]
        end
    end
endmodule : cidc_classify
`default_nettype wire

// *** cidc_decoder.sv ***
// Control-instruction decoder top: fetch handshake, mode bits, strobes
// Behaviour
// [RL1] A word with top nibble 0100 is a one-cycle bit test of the bit given in bits 11-8 on the data operand, result to the test flag.
// [RL2] Upper byte 0110 1111 is a one-cycle bit test whose bit number comes from the low four bits of the bit-index temporary register.
// [RL3] Words 1011 1110 0100 xxxx are one-cycle bit controls that clear the selected bit when bit 0 is 0 and set it when bit 0 is 1.
// [RL4] Bits 3-1 of a bit control select irq mask, overflow mode, RAM config, sign extension, hold, test flag, external flag pin or carry.
// [RL5] Words BE4C and BE4D drive the external flag pin low and high in one cycle.
// [RL6] Word BE22 enters idle and word BE23 enters deep sleep, which waits for an interrupt.
// [RL7] Upper bytes 0E and 0F load status register 0 or 1 from the operand in two cycles.
// [RL8] Upper bytes 8E and 8F store status register 0 or 1 to the operand in one cycle.
// [RL9] Word 8B00 takes one cycle and changes nothing.
// [RL10] Word BE32 pops the stack into the low accumulator half and BE3C pushes it, one cycle each.
// [RL11] Upper byte 8A pops the stack to data memory and 76 pushes data memory onto the stack, one cycle each.
// [RL12] Single repeat takes its count from a data operand, a following long word or an 8-bit immediate, two cycles in all forms.
// [RL13] Word BEC6 is a two-word two-cycle block loop whose second word is the block end address.
// [RL14] Word BEC5 clears accumulator and product register and repeats the next instruction by the following long word count.
// [RL15] The low byte of memory operands is a mode bit then a seven-bit direct offset or indirect control field.
`timescale 1ns/1ns
`default_nettype none
module cidc_decoder (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_I,
    input wire logic [3:0] BIT_INDEX_TEMP_REG_I,
    input wire logic IRQ_I,
    output logic INSTR_TAKE_O,
    output logic OP_VALID_O,
    output cidc_pkg::cidc_op_t OP_O,
    output logic [1:0] OP_CYCLES_O,
    output logic [3:0] TEST_BIT_SEL_O,
    output logic MEM_INDIRECT_O,
    output logic [6:0] MEM_FIELD_O,
    output logic [15:0] OPERAND2_O,
    output logic [7:0] SHORT_COUNT_O,
    output logic GLOBAL_IRQ_MASK_O,
    output logic OVF_MODE_O,
    output logic RAM_CONFIG_BIT_O,
    output logic SIGN_EXT_MODE_O,
    output logic HOLD_MODE_O,
    output logic TEST_CONTROL_FLAG_O,
    output logic CARRY_O,
    output logic EXTERNAL_FLAG_PIN_O,
    output logic IDLE_O,
    output logic DEEP_SLEEP_O,
    output logic CLEAR_ACC_PRODUCT_REGISTER_O
);
    import cidc_pkg::*;

    cidc_op_t cls_op;
    logic cls_two;
    logic [1:0] cls_cyc;
    cidc_state_t state_r;
    cidc_op_t pend_op_r;
    logic [1:0] pend_cyc_r;
    logic [15:0] pend_word_r;
    logic [1:0] busy_r;
    logic irq_s1_r;
    logic irq_s2_r;
    logic take;
    logic issue1;
    logic [2:0] ctl_sel;

    cidc_classify u_classify (
        .instr_i(INSTR_I),
        .op_o(cls_op),
        .two_word_o(cls_two),
        .cycles_o(cls_cyc)
    );

    // Interrupt arrives from outside this clock; two flops before use
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
        end else begin
            irq_s1_r <= IRQ_I;
            irq_s2_r <= irq_s1_r;
        end
    end

    // Multi-cycle ops hold off the next fetch until their cycles are spent
    assign take = INSTR_VALID_I && (busy_r == 2'h0) &&
                  (state_r == ST_FETCH || state_r == ST_SECOND);
    assign issue1 = take && state_r == ST_FETCH && !cls_two;
    assign ctl_sel = INSTR_I[CTL_HI:CTL_LO];

    // Sequencer: second word of two-word ops, idle and deep sleep
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= ST_FETCH;
            pend_op_r <= OPC_NONE;
            pend_cyc_r <= CYC_ONE;
            pend_word_r <= 16'h0000;
        end else begin
            unique case (state_r)
                ST_FETCH: begin
                    if (take && cls_two) begin
                        state_r <= ST_SECOND; // see [RL13]
                        pend_op_r <= cls_op;
                        pend_cyc_r <= cls_cyc;
                        pend_word_r <= INSTR_I;
                    end else if (take && cls_op == OPC_IDLE) begin
                        state_r <= ST_IDLE; // see [RL6]
                    end else if (take && cls_op == OPC_DEEP_SLEEP) begin
                        state_r <= ST_DEEP; // see [RL6]
                    end
                end
                ST_SECOND: begin
                    if (take) begin
                        state_r <= ST_FETCH;
                    end
                end
                // Plain idle and deep sleep both leave only on the synchronised interrupt
                ST_IDLE, ST_DEEP: begin
                    if (irq_s2_r) begin
                        state_r <= ST_FETCH; // see [RL6]
                    end
                end
            endcase
        end
    end

    // Count the extra cycle of one-word two-cycle ops; the second word of two-word ops clears it
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            busy_r <= 2'h0;
        end else if (issue1 && cls_cyc == CYC_TWO) begin
            busy_r <= CYC_ONE; // see [RL7]
        end else if (take && state_r == ST_SECOND &&
                     pend_cyc_r == CYC_TWO) begin
            busy_r <= 2'h0; // see [RL12]
        end else if (busy_r != 2'h0) begin
            busy_r <= busy_r - CYC_ONE;
        end
    end

    // Issue strobe and decoded fields
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            INSTR_TAKE_O <= 1'b0;
            OP_VALID_O <= 1'b0;
            OP_O <= OPC_NONE;
            OP_CYCLES_O <= CYC_ONE;
            TEST_BIT_SEL_O <= 4'h0;
            MEM_INDIRECT_O <= 1'b0;
            MEM_FIELD_O <= 7'h00;
            OPERAND2_O <= 16'h0000;
            SHORT_COUNT_O <= 8'h00;
            CLEAR_ACC_PRODUCT_REGISTER_O <= 1'b0;
        end else begin
            INSTR_TAKE_O <= take;
            OP_VALID_O <= 1'b0;
            CLEAR_ACC_PRODUCT_REGISTER_O <= 1'b0;
            if (issue1) begin
                OP_VALID_O <= cls_op != OPC_NONE; // see [RL9]
                OP_O <= cls_op;
                OP_CYCLES_O <= cls_cyc;
                MEM_INDIRECT_O <= INSTR_I[MODE_BIT]; // see [RL15]
                MEM_FIELD_O <= INSTR_I[FIELD_HI:0]; // see [RL15]
                SHORT_COUNT_O <= INSTR_I[SHORT_HI:0]; // see [RL12]
                if (cls_op == OPC_VAR_BIT_TEST) begin
                    TEST_BIT_SEL_O <= BIT_INDEX_TEMP_REG_I[TIDX_HI:0]; // see [RL2]
                end else begin
                    TEST_BIT_SEL_O <= INSTR_I[SEL_HI:SEL_LO]; // see [RL1]
                end
            end else if (take && state_r == ST_SECOND) begin
                OP_VALID_O <= 1'b1;
                OP_O <= pend_op_r;
                OP_CYCLES_O <= pend_cyc_r;
                OPERAND2_O <= INSTR_I; // see [RL13]
                CLEAR_ACC_PRODUCT_REGISTER_O <= pend_op_r == OPC_ZERO_LOOP; // see [RL14]
            end
        end
    end

    // Status and mode bits changed by bit control words
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            // Reset levels indexed by selector code, flag pin from XF_RESET, so they match set/clear
            GLOBAL_IRQ_MASK_O <= MODE_RESET[SEL_IRQ_MASK];
            OVF_MODE_O <= MODE_RESET[SEL_OVM];
            RAM_CONFIG_BIT_O <= MODE_RESET[SEL_RAM_CFG];
            SIGN_EXT_MODE_O <= MODE_RESET[SEL_SXM];
            HOLD_MODE_O <= MODE_RESET[SEL_HOLD];
            TEST_CONTROL_FLAG_O <= MODE_RESET[SEL_TC];
            CARRY_O <= MODE_RESET[SEL_CARRY];
            EXTERNAL_FLAG_PIN_O <= XF_RESET;
        end else if (issue1 && (cls_op == OPC_SET_CTL ||
                                cls_op == OPC_CLEAR_CTL)) begin
            unique case (ctl_sel) // see [RL4]
                SEL_IRQ_MASK: GLOBAL_IRQ_MASK_O <= INSTR_I[0]; // see [RL3]
                SEL_OVM: OVF_MODE_O <= INSTR_I[0];
                SEL_RAM_CFG: RAM_CONFIG_BIT_O <= INSTR_I[0];
                SEL_SXM: SIGN_EXT_MODE_O <= INSTR_I[0];
                SEL_HOLD: HOLD_MODE_O <= INSTR_I[0];
                SEL_TC: TEST_CONTROL_FLAG_O <= INSTR_I[0];
                SEL_XF: EXTERNAL_FLAG_PIN_O <= INSTR_I[0]; // see [RL5]
                SEL_CARRY: CARRY_O <= INSTR_I[0];
            endcase
        end
    end

    // Idle indications follow the sequencer state
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            IDLE_O <= 1'b0;
            DEEP_SLEEP_O <= 1'b0;
        end else begin
            IDLE_O <= (state_r == ST_IDLE); // see [RL6]
            DEEP_SLEEP_O <= (state_r == ST_DEEP); // see [RL6]
        end
    end
endmodule : cidc_decoder
`default_nettype wire

// *** cidc_decoder_bench.sv ***
// Self-checking bench for the control-instruction decoder
`timescale 1ns/1ns
`default_nettype none
module cidc_decoder_bench;
    import cidc_pkg::*;
    typedef struct {cidc_op_t op; logic [15:0] w; logic [15:0] w2;} cidc_exp_t;
    logic clk = 1'b0, rst_n = 1'b0, irq = 1'b0, stall = 1'b0, stall_en = 1'b0;
    logic valid, take, opv, mind, im, ov, rc, sx, hd, tc, cy, xf, idl, dp, clr;
    logic [15:0] instr, op2;
    logic [3:0] treg = 4'h0, tsel;
    logic [6:0] mfld;
    logic [7:0] scnt, m = 8'h41;
    logic [1:0] cyc;
    cidc_op_t op;
    cidc_exp_t exp_q[$];
    int seed = 32'h1963, fail_count = 0, samples_checked = 0;
    logic [7:0] ubs[10] = '{8'h40, 8'h6F, 8'h0E, 8'h0F, 8'h8E, 8'h8F, 8'h8A,
        8'h76, 8'h0B, 8'hBB};
    logic [15:0] fx[6] = '{16'h8B00, 16'hBE32, 16'hBE3C, 16'hBEC4, 16'hBEC6,
        16'hBEC5};
    always #50 clk = ~clk;
    cidc_prog_mem cidc_prog_mem_i (.clk_i(clk), .take_i(take),
        .stall_i(stall), .valid_o(valid), .word_o(instr));
    cidc_decoder cidc_decoder_i (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .INSTR_VALID_I(valid), .INSTR_I(instr), .BIT_INDEX_TEMP_REG_I(treg),
        .IRQ_I(irq), .INSTR_TAKE_O(take), .OP_VALID_O(opv), .OP_O(op),
        .OP_CYCLES_O(cyc), .TEST_BIT_SEL_O(tsel), .MEM_INDIRECT_O(mind),
        .MEM_FIELD_O(mfld), .OPERAND2_O(op2), .SHORT_COUNT_O(scnt),
        .GLOBAL_IRQ_MASK_O(im), .OVF_MODE_O(ov), .RAM_CONFIG_BIT_O(rc),
        .SIGN_EXT_MODE_O(sx), .HOLD_MODE_O(hd), .TEST_CONTROL_FLAG_O(tc),
        .CARRY_O(cy), .EXTERNAL_FLAG_PIN_O(xf), .IDLE_O(idl),
        .DEEP_SLEEP_O(dp), .CLEAR_ACC_PRODUCT_REGISTER_O(clr));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    function automatic cidc_op_t exp_op(input logic [15:0] w);
        casez (w)
            16'h4???: return OPC_BIT_IMM;
            16'h6F??: return OPC_VAR_BIT_TEST;
            16'hBE4?: return w[0] ? OPC_SET_CTL : OPC_CLEAR_CTL;
            16'hBE22: return OPC_IDLE;
            16'hBE23: return OPC_DEEP_SLEEP;
            16'h0E??: return OPC_LOAD_ST0;
            16'h0F??: return OPC_LOAD_ST1;
            16'h8E??: return OPC_STORE_ST0;
            16'h8F??: return OPC_STORE_ST1;
            16'h8B00: return OPC_NOP;
            16'hBE32: return OPC_POP_ACC_LOW_HALF;
            16'hBE3C: return OPC_PUSH_ACC_LOW_HALF;
            16'h8A??: return OPC_STACK_TO_MEM;
            16'h76??: return OPC_MEM_TO_STACK;
            16'h0B??: return OPC_RPT_DATA;
            16'hBEC4: return OPC_RPT_LONG;
            16'hBB??: return OPC_RPT_SHORT;
            16'hBEC6: return OPC_BLOCK_LOOP;
            16'hBEC5: return OPC_ZERO_LOOP;
            default: return OPC_NONE;
        endcase
    endfunction : exp_op
    function automatic logic two_w(input cidc_op_t o);
        return o inside {OPC_RPT_LONG, OPC_BLOCK_LOOP, OPC_ZERO_LOOP};
    endfunction : two_w
    task automatic issue(input logic [15:0] w, input logic [15:0] w2);
        cidc_exp_t e;
        e = '{exp_op(w), w, w2};
        cidc_prog_mem_i.push(w);
        if (two_w(e.op)) cidc_prog_mem_i.push(w2);
        if (e.op != OPC_NONE) exp_q.push_back(e);
    endtask : issue
    task automatic pick(input int k, input logic [31:0] r);
        logic [15:0] w;
        w = (k < 10) ? {ubs[k], r[7:0]} : fx[k-10];
        if (k == 0) w[11:8] = r[11:8];
        issue(w, r[31:16]);
    endtask : pick
    task automatic drain();
        int n;
        n = 0;
        while ((exp_q.size() > 0 || cidc_prog_mem_i.words_q.size() > 0)
            && n < 500) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
        check(exp_q.size(), 0);
    endtask : drain
    task automatic sleep_wake(input logic [15:0] w);
        issue(w, 16'h0000);
        issue(16'h8B00, 16'h0000);
        repeat (12) @(negedge clk);
        check(exp_q.size(), 1);
        check({idl, dp}, {w == OP_IDLE, w == OP_DEEP_SLEEP});
        irq = 1'b1;
        drain();
        irq = 1'b0;
        // Let the synchroniser clear, or the next sleep would wake at once
        repeat (3) @(negedge clk);
    endtask : sleep_wake
    always @(negedge clk) begin
        logic [31:0] sr;
        sr = $random(seed);
        stall <= stall_en & sr[0];
    end
    always @(negedge clk) begin
        cidc_exp_t e;
        if (rst_n && opv) begin
            // Nothing expected: any issue strobe here is spurious
            if (exp_q.size() == 0) check(opv, 1'b0);
            else begin
                e = exp_q.pop_front();
                check(op, e.op);
                check(cyc, (two_w(e.op) || e.op inside {
                    OPC_LOAD_ST0, OPC_LOAD_ST1, OPC_RPT_DATA,
                    OPC_RPT_SHORT}) ? 2 : 1);
                if (e.op == OPC_BIT_IMM) check(tsel, e.w[11:8]);
                if (e.op == OPC_VAR_BIT_TEST) check(tsel, treg);
                if (e.op inside {OPC_BIT_IMM, OPC_VAR_BIT_TEST, OPC_LOAD_ST0,
                    OPC_LOAD_ST1, OPC_STORE_ST0, OPC_STORE_ST1, OPC_RPT_DATA,
                    OPC_STACK_TO_MEM, OPC_MEM_TO_STACK})
                    check({mind, mfld}, e.w[7:0]);
                if (e.op == OPC_RPT_SHORT) check(scnt, e.w[7:0]);
                if (two_w(e.op)) check(op2, e.w2);
                check(clr, e.op == OPC_ZERO_LOOP);
                if (e.op inside {OPC_SET_CTL, OPC_CLEAR_CTL})
                    m[e.w[3:1]] = e.w[0];
                check({cy, xf, tc, hd, sx, rc, ov, im}, m);
                // Idle levels follow the state one edge after the issue
                check({idl, dp}, 2'h0);
            end
        end
    end
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (8000) @(posedge clk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
    initial begin
        logic [31:0] r;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        check({cy, xf, tc, hd, sx, rc, ov, im, cyc},
            {8'h41, 2'h1});
        $display("test reset done");
        for (int j = 0; j < 16; j++)
            issue(16'hBE40 | {j[2:0], ~j[3]}, 16'h0000);
        drain();
        $display("test bit control done");
        r = $random(seed);
        treg = r[3:0];
        for (int k = 0; k < 16; k++) pick(k, $random(seed));
        issue(16'hFFFF, 16'h0000);
        drain();
        sleep_wake(16'hBE22);
        sleep_wake(16'hBE23);
        $display("test opcode table done");
        stall_en = 1'b1;
        for (int i = 0; i < 80; i++) begin
            r = $random(seed);
            pick(r[19:16], $random(seed));
        end
        drain();
        $display("test random stream done");
        results();
    end
endmodule : cidc_decoder_bench
`default_nettype wire

// *** cidc_pkg.sv ***
// Package with opcode fields, encodings and timing constants for the decoder
package cidc_pkg;
    localparam int INSTR_W = 16;
    localparam int CYC_W = 2;
    // Opcode field positions
    localparam int NIB_HI = 15;
    localparam int NIB_LO = 12;
    localparam int BYTE_HI = 15;
    localparam int BYTE_LO = 8;
    localparam int SEL_HI = 11;
    localparam int SEL_LO = 8;
    localparam int CTL_HI = 3;
    localparam int CTL_LO = 1;
    localparam int MODE_BIT = 7;
    localparam int FIELD_HI = 6;
    localparam int SHORT_HI = 7;
    localparam int TIDX_HI = 3;
    // Encodings
    localparam logic [3:0] OP_BIT_IMM = 4'h4;
    localparam logic [7:0] OP_VAR_BIT_TEST = 8'h6F;
    localparam logic [11:0] OP_CTL_GROUP = 12'hBE4;
    localparam logic [15:0] OP_IDLE = 16'hBE22;
    localparam logic [15:0] OP_DEEP_SLEEP = 16'hBE23;
    localparam logic [7:0] OP_LOAD_ST0 = 8'h0E;
    localparam logic [7:0] OP_LOAD_ST1 = 8'h0F;
    localparam logic [7:0] OP_STORE_ST0 = 8'h8E;
    localparam logic [7:0] OP_STORE_ST1 = 8'h8F;
    localparam logic [15:0] OP_NOP = 16'h8B00;
    localparam logic [15:0] OP_POP_ACC_LOW_HALF = 16'hBE32;
    localparam logic [15:0] OP_PUSH_ACC_LOW_HALF = 16'hBE3C;
    localparam logic [7:0] OP_STACK_TO_MEM = 8'h8A;
    localparam logic [7:0] OP_MEM_TO_STACK = 8'h76;
    localparam logic [7:0] OP_RPT_DATA = 8'h0B;
    localparam logic [15:0] OP_RPT_LONG = 16'hBEC4;
    localparam logic [7:0] OP_RPT_SHORT = 8'hBB;
    localparam logic [15:0] OP_BLOCK_LOOP = 16'hBEC6;
    localparam logic [15:0] OP_ZERO_LOOP = 16'hBEC5;
    // Bit-control selector codes
    localparam logic [2:0] SEL_IRQ_MASK = 3'h0;
    localparam logic [2:0] SEL_OVM = 3'h1;
    localparam logic [2:0] SEL_RAM_CFG = 3'h2;
    localparam logic [2:0] SEL_SXM = 3'h3;
    localparam logic [2:0] SEL_HOLD = 3'h4;
    localparam logic [2:0] SEL_TC = 3'h5;
    localparam logic [2:0] SEL_XF = 3'h6;
    localparam logic [2:0] SEL_CARRY = 3'h7;
    // Cycle counts
    localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
    localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;
    // Mode bit reset values
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic XF_RESET = 1'b1;

    typedef enum logic [4:0] {
        OPC_NONE, OPC_BIT_IMM, OPC_VAR_BIT_TEST, OPC_CLEAR_CTL, OPC_SET_CTL,
        OPC_IDLE, OPC_DEEP_SLEEP, OPC_LOAD_ST0, OPC_LOAD_ST1, OPC_STORE_ST0,
        OPC_STORE_ST1, OPC_NOP, OPC_POP_ACC_LOW_HALF, OPC_PUSH_ACC_LOW_HALF,
        OPC_STACK_TO_MEM, OPC_MEM_TO_STACK, OPC_RPT_DATA, OPC_RPT_LONG,
        OPC_RPT_SHORT, OPC_BLOCK_LOOP, OPC_ZERO_LOOP
    } cidc_op_t;

    typedef enum logic [1:0] {
        ST_FETCH, ST_SECOND, ST_IDLE, ST_DEEP
    } cidc_state_t;
endpackage : cidc_pkg

// *** cidc_prog_mem.sv ***
// Program memory model presenting queued instruction words
`timescale 1ns/1ns
`default_nettype none
module cidc_prog_mem (
    input wire logic clk_i,
    input wire logic take_i,
    input wire logic stall_i,
    output logic valid_o,
    output logic [15:0] word_o
);
    logic [15:0] words_q[$];
    initial begin
        valid_o = 1'b0;
        word_o = 16'h0000;
    end
    task automatic push(input logic [15:0] w);
        words_q.push_back(w);
    endtask : push
    // Stalls only between words: a presented word is held until taken
    always @(negedge clk_i) begin
        if (take_i && words_q.size() > 0) words_q.pop_front();
        if (words_q.size() > 0 && !(stall_i && (!valid_o || take_i))) begin
            valid_o <= 1'b1;
            word_o <= words_q[0];
        end else begin
            valid_o <= 1'b0;
            word_o <= ~word_o;
        end
    end
endmodule : cidc_prog_mem
`default_nettype wire
